// ### hw/albd_pkg.sv
// Shared constants and types for the arithmetic, logic and branch decoder
//
// Contract
// - Add-with-carry sums accumulator, carry and file byte
// - Add-with-carry updates N, OV, C, DC, Z
// - Destination bit zero selects accumulator, one selects file
// - Bank bit zero uses access bank, one uses bank pointer
// - Extended set, bank zero, address <=95 uses indexed offset
// - AND with file updates only N and Z
// - AND with literal uses eight-bit literal field
// - AND with literal writes accumulator, updates N, Z only
// - Clear file bit zeroes one bit, flags untouched
// - Branch on carry when carry is one
// - Branch without carry when carry is zero
// - Branch on negative when negative is one
// - Branch not negative when negative is zero
// - Taken target is incremented address plus twice offset
// - Not taken one cycle, taken adds a no-operation cycle
package albd_pkg;

  // Opcode fields of the instruction word
  localparam logic [5:0] OP_ADD_CARRY = 6'h08;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [7:0] OP_AND_LIT = 8'h0B;
  localparam logic [3:0] OP_CLR_BIT = 4'h9;
  localparam logic [7:0] OP_BR_CARRY = 8'hE2;
  localparam logic [7:0] OP_BR_NO_CARRY = 8'hE3;
  localparam logic [7:0] OP_BR_NEG = 8'hE6;
  localparam logic [7:0] OP_BR_NOT_NEG = 8'hE7;

  // Field positions
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int BIT_IDX_LSB = 9;

  // Addressing limits
  localparam logic [7:0] INDEXED_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam int DATA_ADDR_W = 12;

  // Status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;

  // Register byte offsets on the bus
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_ACCUM = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BANK_SEL = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_INDEX_BASE = 8'h14;
  localparam logic [7:0] REG_CORE_STATE = 8'h18;

  // Control bits and reset values
  localparam int CTL_RUN = 0;
  localparam int CTL_EXT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h1;
  localparam logic [7:0] PC_STEP = 8'h02;

  // Operation handed to the arithmetic unit
  typedef enum logic [1:0] {
    ALU_NONE = 2'h0,
    ALU_ADD_CARRY = 2'h1,
    ALU_AND = 2'h2,
    ALU_CLR_BIT = 2'h3
  } albd_alu_op_type;

  // Decoded instruction kind
  typedef enum logic [3:0] {
    K_NOP = 4'h0,
    K_ADD_CARRY = 4'h1,
    K_AND_FILE = 4'h2,
    K_AND_LIT = 4'h3,
    K_CLR_BIT = 4'h4,
    K_BR_CARRY = 4'h5,
    K_BR_NO_CARRY = 4'h6,
    K_BR_NEG = 4'h7,
    K_BR_NOT_NEG = 4'h8
  } albd_kind_type;

  // Quarter-cycle phase, one-hot
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } albd_phase_type;

endpackage

// ### hw/albd_op_if.sv
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ps
interface albd_op_if;
  albd_pkg::albd_alu_op_type op; // Operation to perform
  logic [7:0] accum; // Accumulator value
  logic [7:0] operand; // File byte or literal
  logic [2:0] bit_idx; // Bit index for bit clear
  logic [4:0] status_in; // Current flags
  logic [7:0] result; // Computed byte
  logic [4:0] status_out; // Flags after the operation
  modport core (output op, accum, operand, bit_idx, status_in, input result, status_out);
  modport alu (input op, accum, operand, bit_idx, status_in, output result, status_out);
endinterface

// ### hw/albd_alu.sv
// Arithmetic unit: add with carry, AND, bit clear and flag generation
`timescale 1ns/1ps
module albd_alu (
  albd_op_if.alu ops
);
  logic [8:0] sum; // Full sum with carry out
  logic [4:0] low_sum; // Low nibble sum for digit carry

  // Result and flag computation
  always_comb begin
    sum = {1'b0, ops.accum} + {1'b0, ops.operand} + {8'h00, ops.status_in[albd_pkg::ST_C]};
    low_sum = {1'b0, ops.accum[3:0]} + {1'b0, ops.operand[3:0]}
      + {4'h0, ops.status_in[albd_pkg::ST_C]};
    ops.result = 8'h00;
    ops.status_out = ops.status_in;
    unique case (ops.op)
      albd_pkg::ALU_ADD_CARRY: begin
        ops.result = sum[7:0];
        ops.status_out[albd_pkg::ST_C] = sum[8];
        ops.status_out[albd_pkg::ST_DC] = low_sum[4];
        ops.status_out[albd_pkg::ST_Z] = (sum[7:0] == 8'h00);
        ops.status_out[albd_pkg::ST_OV] = (ops.accum[7] == ops.operand[7])
          && (sum[7] != ops.accum[7]);
        ops.status_out[albd_pkg::ST_N] = sum[7];
      end
      albd_pkg::ALU_AND: begin
        ops.result = ops.accum & ops.operand;
        ops.status_out[albd_pkg::ST_Z] = ((ops.accum & ops.operand) == 8'h00);
        ops.status_out[albd_pkg::ST_N] = ops.accum[7] & ops.operand[7];
      end
      albd_pkg::ALU_CLR_BIT: begin
        ops.result = ops.operand & ~(8'h01 << ops.bit_idx);
      end
      albd_pkg::ALU_NONE: begin
        ops.result = 8'h00;
      end
    endcase
  end
endmodule

// ### hw/albd_addr.sv
// Data address resolution for file operands
`timescale 1ns/1ps
module albd_addr (
  input wire logic [7:0] file_addr,
  input wire logic bank_bit,
  input wire logic ext_enable,
  input wire logic [3:0] bank_select_pointer,
  input wire logic [11:0] index_base,
  output logic [11:0] data_addr
);
  // Bank pointer, indexed offset or access bank
  always_comb begin
    if (bank_bit) begin
      data_addr = {bank_select_pointer, file_addr};
    end else if (ext_enable && (file_addr <= albd_pkg::INDEXED_MAX)) begin
      data_addr = index_base + {4'h0, file_addr};
    end else if (file_addr < albd_pkg::ACCESS_SPLIT) begin
      data_addr = {4'h0, file_addr};
    end else begin
      data_addr = {albd_pkg::ACCESS_HIGH_BANK, file_addr};
    end
  end
endmodule

// ### hw/albd_core.sv
// Decode and execute core for add, AND, bit clear and conditional branches
`timescale 1ns/1ps
module albd_core #(
  parameter int PC_WIDTH = 21
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic [PC_WIDTH-1:0] fetch_addr,
  output logic [11:0] mem_addr,
  output logic mem_re,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  // Program counter step at this width
  localparam logic [PC_WIDTH-1:0] PC_INC = PC_WIDTH'(albd_pkg::PC_STEP);

  // Architectural state
  logic [7:0] accum; // Accumulator
  logic [4:0] status; // N, OV, Z, DC, C
  logic [3:0] bank_select_pointer; // Upper address bits for banked access
  logic [11:0] index_base; // Base for indexed literal offset access
  logic [PC_WIDTH-1:0] pc; // Next fetch address
  logic [1:0] control; // Run and extended-set enable

  // Pipeline state
  albd_pkg::albd_phase_type phase; // Current quarter phase
  albd_pkg::albd_kind_type kind; // Instruction in execution
  logic [15:0] ir; // Latched instruction word
  logic [7:0] operand; // Operand read in the second phase
  logic [7:0] result; // Result computed in the third phase
  logic [4:0] next_status; // Flags computed in the third phase
  logic take; // Branch condition held
  logic [PC_WIDTH-1:0] target; // Branch destination
  logic flush; // Current cycle is a forced no-operation

  // Combinational helpers
  logic accept; // Instruction taken this phase
  albd_pkg::albd_kind_type next_kind; // Decode of the incoming word
  logic [11:0] resolved_addr; // Resolved data address
  logic to_file; // Result goes to data memory
  logic bus_req; // Bus request active
  logic bus_write; // Write takes effect at this edge

  // Operand bundle to the arithmetic unit
  albd_op_if ops ();

  // Classifies an instruction word
  function automatic albd_pkg::albd_kind_type decode(input logic [15:0] w);
    albd_pkg::albd_kind_type k;
    k = albd_pkg::K_NOP;
    if (w[15:10] == albd_pkg::OP_ADD_CARRY) begin
      k = albd_pkg::K_ADD_CARRY;
    end else if (w[15:10] == albd_pkg::OP_AND_FILE) begin
      k = albd_pkg::K_AND_FILE;
    end else if (w[15:8] == albd_pkg::OP_AND_LIT) begin
      k = albd_pkg::K_AND_LIT;
    end else if (w[15:12] == albd_pkg::OP_CLR_BIT) begin
      k = albd_pkg::K_CLR_BIT;
    end else if (w[15:8] == albd_pkg::OP_BR_CARRY) begin
      k = albd_pkg::K_BR_CARRY;
    end else if (w[15:8] == albd_pkg::OP_BR_NO_CARRY) begin
      k = albd_pkg::K_BR_NO_CARRY;
    end else if (w[15:8] == albd_pkg::OP_BR_NEG) begin
      k = albd_pkg::K_BR_NEG;
    end else if (w[15:8] == albd_pkg::OP_BR_NOT_NEG) begin
      k = albd_pkg::K_BR_NOT_NEG;
    end
    return k;
  endfunction

  // True for kinds that read a file operand
  function automatic logic reads_file(input albd_pkg::albd_kind_type k);
    return (k == albd_pkg::K_ADD_CARRY) || (k == albd_pkg::K_AND_FILE)
      || (k == albd_pkg::K_CLR_BIT);
  endfunction

  // Merges bus write data into a word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Address resolution for the incoming word
  albd_addr u_addr (
    .file_addr(instr_word[7:0]),
    .bank_bit(instr_word[albd_pkg::BANK_BIT]),
    .ext_enable(control[albd_pkg::CTL_EXT]),
    .bank_select_pointer(bank_select_pointer),
    .index_base(index_base),
    .data_addr(resolved_addr)
  );

  // Arithmetic unit
  albd_alu u_alu (
    .ops(ops.alu)
  );

  // Drive the operand bundle
  always_comb begin
    unique case (kind)
      albd_pkg::K_ADD_CARRY: ops.op = albd_pkg::ALU_ADD_CARRY;
      albd_pkg::K_AND_FILE, albd_pkg::K_AND_LIT: ops.op = albd_pkg::ALU_AND;
      albd_pkg::K_CLR_BIT: ops.op = albd_pkg::ALU_CLR_BIT;
      default: ops.op = albd_pkg::ALU_NONE;
    endcase
    ops.accum = accum;
    ops.operand = operand;
    ops.bit_idx = ir[albd_pkg::BIT_IDX_LSB +: 3];
    ops.status_in = status;
  end

  // Fetch handshake and decode of the incoming word
  assign instr_ready = (phase == albd_pkg::PH_Q1) && control[albd_pkg::CTL_RUN] && !flush;
  assign accept = instr_ready && instr_valid;
  assign next_kind = decode(instr_word);
  assign fetch_addr = pc;

  // Destination select: bit clear always writes back, literal AND never
  assign to_file = (kind == albd_pkg::K_CLR_BIT)
    || (((kind == albd_pkg::K_ADD_CARRY) || (kind == albd_pkg::K_AND_FILE))
        && ir[albd_pkg::DEST_BIT]);

  // Bus handshake terms
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_write = bus_req && wb_we_i && wb_ack_o;

  // Quarter phase sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= albd_pkg::PH_Q1;
    end else begin
      unique case (phase)
        albd_pkg::PH_Q1: phase <= albd_pkg::PH_Q2;
        albd_pkg::PH_Q2: phase <= albd_pkg::PH_Q3;
        albd_pkg::PH_Q3: phase <= albd_pkg::PH_Q4;
        albd_pkg::PH_Q4: phase <= albd_pkg::PH_Q1;
      endcase
    end
  end

  // First phase: latch and decode the instruction
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      kind <= albd_pkg::K_NOP;
      ir <= 16'h0000;
    end else if (phase == albd_pkg::PH_Q1) begin
      if (accept) begin
        kind <= next_kind;
        ir <= instr_word;
      end else begin
        // No word this phase: the cycle runs as a no-operation
        kind <= albd_pkg::K_NOP;
      end
    end
  end

  // Data memory read port, active through the second phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_addr <= 12'h000;
      mem_re <= 1'b0;
    end else if (phase == albd_pkg::PH_Q1) begin
      mem_addr <= resolved_addr;
      mem_re <= accept && reads_file(next_kind);
    end else begin
      // Read strobe lasts one cycle
      mem_re <= 1'b0;
    end
  end

  // Second phase: capture the operand
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      operand <= 8'h00;
    end else if (phase == albd_pkg::PH_Q2) begin
      if (kind == albd_pkg::K_AND_LIT) begin
        operand <= ir[7:0];
      end else begin
        operand <= mem_rdata;
      end
    end
  end

  // Third phase: compute result, flags and branch decision
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result <= 8'h00;
      next_status <= 5'h00;
      take <= 1'b0;
      target <= '0;
    end else if (phase == albd_pkg::PH_Q3) begin
      result <= ops.result;
      next_status <= ops.status_out;
      target <= pc + {{(PC_WIDTH-9){ir[7]}}, ir[7:0], 1'b0};
      unique case (kind)
        albd_pkg::K_BR_CARRY: take <= status[albd_pkg::ST_C];
        albd_pkg::K_BR_NO_CARRY: take <= !status[albd_pkg::ST_C];
        albd_pkg::K_BR_NEG: take <= status[albd_pkg::ST_N];
        albd_pkg::K_BR_NOT_NEG: take <= !status[albd_pkg::ST_N];
        default: take <= 1'b0;
      endcase
    end
  end

  // Data memory write port, active through the fourth phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
    end else if (phase == albd_pkg::PH_Q3) begin
      mem_we <= to_file;
      mem_wdata <= ops.result;
    end else begin
      // Write strobe lasts one cycle
      mem_we <= 1'b0;
    end
  end

  // No-operation cycle after a taken branch
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flush <= 1'b0;
    end else if (phase == albd_pkg::PH_Q4) begin
      // Held through the whole next instruction cycle
      flush <= take;
    end
  end

  // Accumulator: core write in the fourth phase wins over the bus
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      accum <= 8'h00;
    end else if ((phase == albd_pkg::PH_Q4) && !to_file
                 && (ops.op != albd_pkg::ALU_NONE)) begin
      accum <= result;
    end else if (bus_write && (wb_adr_i == albd_pkg::REG_ACCUM)) begin
      // Bus write keeps the low byte only
      accum <= 8'(merge({24'h000000, accum}, wb_dat_i, wb_sel_i));
    end
  end

  // Status flags: core write in the fourth phase wins over the bus
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status <= 5'h00;
    end else if ((phase == albd_pkg::PH_Q4) && (ops.op != albd_pkg::ALU_NONE)) begin
      status <= next_status;
    end else if (bus_write && (wb_adr_i == albd_pkg::REG_STATUS)) begin
      // Bus write keeps the five flag bits only
      status <= 5'(merge({27'h0000000, status}, wb_dat_i, wb_sel_i));
    end
  end

  // Program counter: advance on fetch, load on taken branch
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc <= '0;
    end else if (accept) begin
      // Step past the accepted word
      pc <= pc + PC_INC;
    end else if ((phase == albd_pkg::PH_Q4) && take) begin
      pc <= target;
    end else if (bus_write && (wb_adr_i == albd_pkg::REG_PC)) begin
      // Bus write keeps the counter width only
      pc <= PC_WIDTH'(merge(32'(pc), wb_dat_i, wb_sel_i));
    end
  end

  // Software-only registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control <= albd_pkg::CONTROL_RESET;
      bank_select_pointer <= 4'h0;
      index_base <= 12'h000;
    end else if (bus_write) begin
      unique case (wb_adr_i)
        albd_pkg::REG_CONTROL: begin
          // Run and extended-set bits only
          control <= 2'(merge({30'h00000000, control}, wb_dat_i, wb_sel_i));
        end
        albd_pkg::REG_BANK_SEL: begin
          // Four pointer bits only
          bank_select_pointer <= 4'(merge({28'h0000000, bank_select_pointer}, wb_dat_i,
                                          wb_sel_i));
        end
        albd_pkg::REG_INDEX_BASE: begin
          // Twelve base bits only
          index_base <= 12'(merge({20'h00000, index_base}, wb_dat_i, wb_sel_i));
        end
        default: begin
          index_base <= index_base;
        end
      endcase
    end
  end

  // Bus acknowledge, one cycle after the request, dropped after one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      // One pulse per request, low again in the next cycle
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // Bus read data, captured with the request; unmapped reads as zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_ack_o) begin
      unique case (wb_adr_i)
        albd_pkg::REG_CONTROL: wb_dat_o <= {30'h00000000, control};
        albd_pkg::REG_ACCUM: wb_dat_o <= {24'h000000, accum};
        albd_pkg::REG_STATUS: wb_dat_o <= {27'h0000000, status};
        albd_pkg::REG_BANK_SEL: wb_dat_o <= {28'h0000000, bank_select_pointer};
        albd_pkg::REG_PC: wb_dat_o <= 32'(pc);
        albd_pkg::REG_INDEX_BASE: wb_dat_o <= {20'h00000, index_base};
        albd_pkg::REG_CORE_STATE: wb_dat_o <= {23'h000000, flush, kind, phase};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule

// ### test/albd_mem_model.sv
// Behavioural data memory on the far side of the decode core
`timescale 1ns/1ps
module albd_mem_model (
  input wire logic clock,
  input wire logic [11:0] mem_addr,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095]; // One byte per data address
  // Fill repeats every 256 addresses, so only a wrong low address byte reads a wrong byte
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  // Valid only while the core reads; otherwise a scrambled byte
  assign mem_rdata = mem_re ? mem[mem_addr] : ~mem[mem_addr];
  // Write lands at the edge that ends the fourth phase
  always @(posedge clock) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// ### test/albd_core_sva.sv
// Port-level timing checks for the decode core
`timescale 1ns/1ps
module albd_core_sva #(
  parameter int PC_WIDTH = 21
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [PC_WIDTH-1:0] fetch_addr,
  input wire logic [11:0] mem_addr,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata
);
  logic take; // Word accepted at this edge
  logic is_bf; // Add-with-carry or AND with file
  logic is_clr; // Bit clear
  logic is_br; // Conditional branch
  logic [PC_WIDTH-1:0] tgt; // Target if the branch is taken
  assign take = instr_valid && instr_ready;
  assign is_bf = instr_word[15:10] == 6'h08 || instr_word[15:10] == 6'h05;
  assign is_clr = instr_word[15:12] == 4'h9;
  assign is_br = instr_word[15:8] inside {8'hE2, 8'hE3, 8'hE6, 8'hE7};
  assign tgt = fetch_addr + PC_WIDTH'(2) + PC_WIDTH'($signed({instr_word[7:0], 1'b0}));
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  operand_read_a: assert property (take && (is_bf || is_clr) |=> mem_re)
    else $error("file operand not read in second phase");
  file_dest_a: assert property (take && is_bf && instr_word[9] |-> ##1 mem_re ##2 mem_we)
    else $error("file destination not written in fourth phase");
  accum_dest_a: assert property (take && is_bf && !instr_word[9] |-> ##3 !mem_we)
    else $error("accumulator destination wrote memory");
  literal_no_write_a: assert property (take && instr_word[15:8] == 8'h0B |-> ##3 !mem_we)
    else $error("literal AND wrote memory");
  bit_clear_a: assert property (take && is_clr |->
    ##3 (mem_we && !mem_wdata[$past(instr_word[11:9], 3)]))
    else $error("selected bit not cleared on write");
  access_bank_a: assert property (take && (is_bf || is_clr) && !instr_word[8] &&
    instr_word[7:0] >= 8'h60 |=> mem_addr == {4'hF, $past(instr_word[7:0])})
    else $error("access bank high address wrong");
  pc_step_a: assert property (take |=> fetch_addr == $past(fetch_addr) + PC_WIDTH'(2))
    else $error("fetch address not stepped on accept");
  branch_target_a: assert property (take && is_br |-> ##4
    (fetch_addr == $past(tgt, 4) || fetch_addr == $past(fetch_addr, 4) + PC_WIDTH'(2)))
    else $error("branch left a wrong fetch address");
  flush_taken_a: assert property (take && is_br ##4 (fetch_addr == $past(tgt, 4) &&
    fetch_addr != $past(fetch_addr, 4) + PC_WIDTH'(2)) |-> !instr_ready)
    else $error("no flush cycle after taken branch");
  ready_once_a: assert property (rstn && instr_ready |=> !instr_ready [*3])
    else $error("fetch ready outside first phase");
endmodule
bind albd_core albd_core_sva #(.PC_WIDTH(PC_WIDTH)) sva_i (
  .clock(clock), .rstn(rstn), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .fetch_addr(fetch_addr), .mem_addr(mem_addr), .mem_re(mem_re),
  .mem_we(mem_we), .mem_wdata(mem_wdata));

// ### test/tb_top.sv
// Self-checking bench for the decode core
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [15:0] word; // Instruction
    logic [7:0] acc; // Accumulator before
    logic [4:0] st; // Flags before
    logic [11:0] addr; // Operand data address
    logic [7:0] mem; // Operand byte before
    logic [7:0] acc_x; // Accumulator after
    logic [4:0] st_x; // Flags after
    logic [7:0] mem_x; // Operand byte after
    logic [1:0] br; // 0 none, 1 not taken, 2 taken
  } albd_row_type;
  logic clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid, instr_ready;
  logic [7:0] wb_adr_i, mem_rdata, mem_wdata;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] instr_word;
  logic [20:0] fetch_addr;
  logic [11:0] mem_addr;
  logic mem_re, mem_we;
  int fails = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int cycles = 0; // Watchdog count
  albd_row_type rows [16]; // Ordinary cases
  albd_core #(.PC_WIDTH(21)) uut (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .fetch_addr(fetch_addr), .mem_addr(mem_addr),
    .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  albd_mem_model mem_i (
    .clock(clock), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Watchdog against a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  // Verdict and end of run
  task automatic results;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compare a register-sized value
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare a single flag
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  // One classic bus cycle; waits for the acknowledge
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rd);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Offer a word, then settle after the edge that ends the fourth phase
  task automatic run_instr(input logic [15:0] w, output logic [20:0] here);
    @(posedge clock);
    instr_word <= w;
    instr_valid <= 1'b1;
    do @(posedge clock); while (instr_ready !== 1'b1);
    here = fetch_addr;
    instr_valid <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  // Preset state, execute, compare every result
  task automatic run_row(input albd_row_type r);
    logic [31:0] rd;
    logic [20:0] here;
    logic [20:0] pc_x;
    mem_i.mem[r.addr] = r.mem;
    wb_cycle(1'b1, albd_pkg::REG_ACCUM, {24'h0, r.acc}, rd);
    wb_cycle(1'b1, albd_pkg::REG_STATUS, {27'h0, r.st}, rd);
    run_instr(r.word, here);
    pc_x = here + 21'h2;
    if (r.br == 2'h2) begin
      pc_x = pc_x + {{12{r.word[7]}}, r.word[7:0], 1'b0};
    end
    check_bit("fetch ready", r.br != 2'h2, instr_ready);
    check_word("pc", {11'h0, pc_x}, {11'h0, fetch_addr});
    wb_cycle(1'b0, albd_pkg::REG_ACCUM, 32'h0, rd);
    check_word("accum", {24'h0, r.acc_x}, rd);
    wb_cycle(1'b0, albd_pkg::REG_STATUS, 32'h0, rd);
    check_word("status", {27'h0, r.st_x}, rd);
    check_word("data byte", {24'h0, r.mem_x}, {24'h0, mem_i.mem[r.addr]});
  endtask
  // Reset pulse, then reset values and an ignored unmapped write
  task automatic reset_check(input int len);
    logic [31:0] rd;
    logic [7:0] adr;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (len) @(posedge clock);
    rstn <= 1'b1;
    wb_cycle(1'b1, 8'h40, 32'hFFFFFFFF, rd);
    for (int a = 0; a < 7; a++) begin
      adr = (a == 6) ? 8'h40 : 8'(a * 4);
      wb_cycle(1'b0, adr, 32'h0, rd);
      check_word("reset value", (a == 0) ? {30'h0, albd_pkg::CONTROL_RESET} : 32'h0, rd);
    end
    $display("Reset test done");
  endtask
  // Main sequence
  initial begin
    logic [31:0] rd;
    rstn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    rows = '{'{16'h2010, 8'h17, 5'h01, 12'h010, 8'hC2, 8'hDA, 5'h10, 8'hC2, 2'h0},
             '{16'h2340, 8'h7F, 5'h00, 12'h340, 8'h01, 8'h7F, 5'h1A, 8'h80, 2'h0},
             '{16'h2080, 8'hFF, 5'h01, 12'hF80, 8'h00, 8'h00, 5'h07, 8'h00, 2'h0},
             '{16'h1420, 8'h17, 5'h0B, 12'h020, 8'hC2, 8'h02, 5'h0B, 8'hC2, 2'h0},
             '{16'h1705, 8'h0F, 5'h10, 12'h305, 8'hF0, 8'h0F, 5'h04, 8'h00, 2'h0},
             '{16'h0B5F, 8'hA3, 5'h01, 12'h010, 8'h77, 8'h03, 5'h01, 8'h77, 2'h0},
             '{16'h9E30, 8'h55, 5'h1F, 12'h030, 8'hC7, 8'h55, 5'h1F, 8'h47, 2'h0},
             '{16'h91FF, 8'h00, 5'h00, 12'h3FF, 8'h01, 8'h00, 5'h00, 8'h00, 2'h0},
             '{16'hE205, 8'h3C, 5'h01, 12'h010, 8'h00, 8'h3C, 5'h01, 8'h00, 2'h2},
             '{16'hE205, 8'h3C, 5'h00, 12'h010, 8'h00, 8'h3C, 5'h00, 8'h00, 2'h1},
             '{16'hE380, 8'h3C, 5'h00, 12'h010, 8'h00, 8'h3C, 5'h00, 8'h00, 2'h2},
             '{16'hE37F, 8'h3C, 5'h01, 12'h010, 8'h00, 8'h3C, 5'h01, 8'h00, 2'h1},
             '{16'hE67F, 8'h3C, 5'h10, 12'h010, 8'h00, 8'h3C, 5'h10, 8'h00, 2'h2},
             '{16'hE601, 8'h3C, 5'h01, 12'h010, 8'h00, 8'h3C, 5'h01, 8'h00, 2'h1},
             '{16'hE7FE, 8'h3C, 5'h0F, 12'h010, 8'h00, 8'h3C, 5'h0F, 8'h00, 2'h2},
             '{16'hE701, 8'h3C, 5'h10, 12'h010, 8'h00, 8'h3C, 5'h10, 8'h00, 2'h1}};
    reset_check(20);
    wb_cycle(1'b1, albd_pkg::REG_BANK_SEL, 32'h3, rd);
    wb_cycle(1'b1, albd_pkg::REG_INDEX_BASE, 32'h200, rd);
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("Row %0d done", i);
    end
    // Extended set: indexed at the top of the window, access bank just above it
    wb_cycle(1'b1, albd_pkg::REG_CONTROL, 32'h3, rd);
    run_row('{16'h225F, 8'h01, 5'h00, 12'h25F, 8'h10, 8'h01, 5'h00, 8'h11, 2'h0});
    run_row('{16'h2260, 8'h01, 5'h00, 12'hF60, 8'h20, 8'h01, 5'h00, 8'h21, 2'h0});
    $display("Indexed test done");
    reset_check(3);
    results();
  end
endmodule
